// file: inc/bars_consts.svh
// Constants for the bridge converter serial readout block
`ifndef BARS_CONSTS_SVH
`define BARS_CONSTS_SVH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define BARS_CLK_MHZ 250
`define BARS_PD_US 60
`define BARS_SLOW_HZ 10
`define BARS_FAST_HZ 40
`define BARS_SETTLE_SLOW_MS 400
`define BARS_SETTLE_FAST_MS 100

// ---------------------------------------------------------------
// Readout framing
// ---------------------------------------------------------------
`define BARS_DATA_BITS 24
`define BARS_PULSES_SLOW 5'h19
`define BARS_PULSES_FAST 5'h1b
`define BARS_PULSES_DATA 5'h18
`define BARS_PULSES_SAT 5'h1f
`define BARS_PTR_BITS 5

// ---------------------------------------------------------------
// Output codes and reset values
// ---------------------------------------------------------------
`define BARS_CODE_MAX 24'h7f_ffff
`define BARS_CODE_MIN 24'h80_0000
`define BARS_RATE_RESET 1'h0

`endif

// file: inc/bars_pkg.sv
// Types shared by the bridge converter readout modules
package bars_pkg;

	typedef enum logic [3:0] {
		ST_CONV  = 4'h1,
		ST_READY = 4'h2,
		ST_SHIFT = 4'h4,
		ST_PDOWN = 4'h8
	} bars_state_t;

	typedef logic [4:0] bars_ptr_t;

	typedef logic [23:0] bars_word_t;

endpackage : bars_pkg

// file: inc/bars_link_if.sv
// Carrier for the edge pointer from the link domain to the core
`timescale 1ns/10ps
`default_nettype none

interface bars_link_if;
	import bars_pkg::*;

	bars_ptr_t gray;

	modport link (output gray);
	modport core (input gray);

endinterface : bars_link_if

`default_nettype wire

// file: logic/bars_link.sv
// Link-domain edge counter published as a gray pointer
`timescale 1ns/10ps
`default_nettype none

module bars_link (
	input wire logic sclk,
	input wire logic rst_n,
	bars_link_if.link lnk
);
	import bars_pkg::*;

	bars_ptr_t cnt_r;
	bars_ptr_t cnt_nxt;
	bars_ptr_t gray_r;
	bars_ptr_t gray_nxt;

	// -----------------------------------------------------------
	// Counter
	// -----------------------------------------------------------
	// Only one pointer bit moves per edge, so the core may sample
	// it at any time without seeing a torn value.
	always_comb begin
		cnt_nxt = cnt_r + 5'h01;
		gray_nxt = cnt_nxt ^ (cnt_nxt >> 1);
	end

	// Reset release is asynchronous to sclk; safe because the
	// host keeps the line low until the first result is ready.
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 5'h00;
			gray_r <= 5'h00;
		end else begin
			cnt_r <= cnt_nxt;
			gray_r <= gray_nxt;
		end
	end

	assign lnk.gray = gray_r;

endmodule : bars_link

`default_nettype wire

// file: logic/bars_top.sv
// Serial readout, rate selection and power-down of the bridge converter
// How it works
// - Data output stays high while no fresh result waits.
// - Data output goes low when a fresh result is ready.
// - Each rising clock edge presents next bit, MSB first, 24 bits.
// - The 25th pulse returns the data output high.
// - 25 pulses choose 10 Hz, 27 pulses choose 40 Hz.
// - Results are 24-bit two's complement.
// - Out-of-range input clamps to the most negative or positive code.
// - Clock line high over 60 us enters power-down.
// - With the clock line low the device keeps converting.
// - Clock line low after power-down resumes with prior settings.
// - Power-on reset initialises all logic without host action.
// - Leaving power-down applies the last selected rate.
// - Results after power-up or rate change wait out settling.
`timescale 1ns/10ps
`default_nettype none
`include "bars_consts.svh"

module bars_top #(
	parameter int unsigned PD_CYC = `BARS_PD_US * `BARS_CLK_MHZ,
	parameter int unsigned SLOW_CYC =
		(`BARS_CLK_MHZ * 1000000) / `BARS_SLOW_HZ,
	parameter int unsigned FAST_CYC =
		(`BARS_CLK_MHZ * 1000000) / `BARS_FAST_HZ
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic serial_clock_powerdown,
	input wire logic [25:0] sample_in,
	output logic dout,
	output logic switched_sensor_supply,
	output logic rate_fast,
	output logic powered_down,
	output logic comm_error
);
	import bars_pkg::*;

	// ---------------------------------------------------------------
	// Settling in whole conversions
	// ---------------------------------------------------------------
	localparam logic [2:0] SETTLE_SLOW = 3'(
		(`BARS_SETTLE_SLOW_MS * `BARS_SLOW_HZ) / 1000);
	localparam logic [2:0] SETTLE_FAST = 3'(
		(`BARS_SETTLE_FAST_MS * `BARS_FAST_HZ) / 1000);

	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	function automatic bars_ptr_t gray_to_bin(input bars_ptr_t g);
		bars_ptr_t b;
		b = g;
		for (int i = `BARS_PTR_BITS - 2; i >= 0; i--) begin
			b[i] = b[i + 1] ^ g[i];
		end
		return b;
	endfunction : gray_to_bin

	function automatic bars_word_t clamp_code(input logic [25:0] s);
		bars_word_t c;
		c = s[23:0];
		if (!s[25] && (s[24:23] != 2'b00)) begin
			c = `BARS_CODE_MAX;
		end else if (s[25] && (s[24:23] != 2'b11)) begin
			c = `BARS_CODE_MIN;
		end
		return c;
	endfunction : clamp_code

	function automatic logic [2:0] settle_for(input logic fast);
		return fast ? SETTLE_FAST : SETTLE_SLOW;
	endfunction : settle_for

	// ---------------------------------------------------------------
	// Reset synchroniser
	// ---------------------------------------------------------------
	logic rst_s1_r;
	logic rst_n_r;

	// Power-on reset arrives on rstn and clears everything
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// ---------------------------------------------------------------
	// Link domain
	// ---------------------------------------------------------------
	bars_link_if lnk_if ();

	bars_link u_link (
		.sclk (serial_clock_powerdown),
		.rst_n (rst_n_r),
		.lnk (lnk_if.link)
	);

	// ---------------------------------------------------------------
	// Crossings into the core clock
	// ---------------------------------------------------------------
	logic pin_s1_r;
	logic pin_s2_r;
	bars_ptr_t gry_s1_r;
	bars_ptr_t gry_s2_r;

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			gry_s1_r <= 5'h00;
			gry_s2_r <= 5'h00;
		end else begin
			pin_s1_r <= serial_clock_powerdown;
			pin_s2_r <= pin_s1_r;
			gry_s1_r <= lnk_if.gray;
			gry_s2_r <= gry_s1_r;
		end
	end

	// ---------------------------------------------------------------
	// Edge tracking
	// ---------------------------------------------------------------
	// Pulses are at least 50 core cycles apart, so the pointer
	// never runs more than one step ahead of the local copy.
	bars_ptr_t seen_r;
	bars_ptr_t seen_nxt;
	logic edge_evt;

	always_comb begin
		edge_evt = (gray_to_bin(gry_s2_r) != seen_r);
		seen_nxt = edge_evt ? seen_r + 5'h01 : seen_r;
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			seen_r <= 5'h00;
		end else begin
			seen_r <= seen_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Power-down timer
	// ---------------------------------------------------------------
	logic [31:0] hi_cnt_r;
	logic [31:0] hi_cnt_nxt;
	logic pd_hit;

	always_comb begin
		pd_hit = (hi_cnt_r == PD_CYC);
		hi_cnt_nxt = 32'h0000_0000;
		if (pin_s2_r) begin
			hi_cnt_nxt = pd_hit ? hi_cnt_r : hi_cnt_r + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			hi_cnt_r <= 32'h0000_0000;
		end else begin
			hi_cnt_r <= hi_cnt_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Conversion and readout control
	// ---------------------------------------------------------------
	bars_state_t st_r;
	bars_state_t st_nxt;
	logic [31:0] conv_cnt_r;
	logic [31:0] conv_cnt_nxt;
	bars_word_t result_r;
	bars_word_t result_nxt;
	bars_word_t shreg_r;
	bars_word_t shreg_nxt;
	logic [4:0] pulses_r;
	logic [4:0] pulses_nxt;
	logic [2:0] settle_r;
	logic [2:0] settle_nxt;
	logic dout_r;
	logic dout_nxt;
	logic fast_r;
	logic fast_nxt;
	logic supply_r;
	logic supply_nxt;
	logic err_r;
	logic err_nxt;
	logic conv_done;
	logic rate_new;

	always_comb begin
		st_nxt = st_r;
		conv_cnt_nxt = conv_cnt_r + 32'h0000_0001;
		result_nxt = result_r;
		shreg_nxt = shreg_r;
		pulses_nxt = pulses_r;
		settle_nxt = settle_r;
		dout_nxt = dout_r;
		fast_nxt = fast_r;
		supply_nxt = 1'b1;
		err_nxt = err_r;
		rate_new = fast_r;
		conv_done = (conv_cnt_r ==
			((fast_r ? FAST_CYC : SLOW_CYC) - 32'h0000_0001));

		// Rising edges count toward this period's total, saturating at 31; one landing as a period closes outside ST_SHIFT is lost
		if (edge_evt && (pulses_r != `BARS_PULSES_SAT)) begin
			pulses_nxt = pulses_r + 5'h01;
		end

		case (st_r)
			ST_READY: begin
				if (edge_evt) begin
					dout_nxt = result_r[23];
					shreg_nxt = {result_r[22:0], 1'b0};
					st_nxt = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (edge_evt) begin
					if (pulses_r == `BARS_PULSES_DATA) begin
						dout_nxt = 1'b1;
						st_nxt = ST_CONV;
					end else begin
						dout_nxt = shreg_r[23];
						shreg_nxt = {shreg_r[22:0], 1'b0};
					end
				end
			end
			ST_PDOWN: begin
				supply_nxt = !pin_s2_r;
				dout_nxt = 1'b1;
				conv_cnt_nxt = 32'h0000_0000;
				pulses_nxt = 5'h00;
				// Rate register untouched here, so resume reuses it
				if (!pin_s2_r) begin
					st_nxt = ST_CONV;
					settle_nxt = settle_for(fast_r);
				end
			end
			default: begin
				dout_nxt = 1'b1;
			end
		endcase

		// Conversions keep running except in power-down
		if ((st_r != ST_PDOWN) && conv_done) begin
			conv_cnt_nxt = 32'h0000_0000;
			result_nxt = clamp_code(sample_in);
			// A readout still in flight closes in the next period
			if (st_r != ST_SHIFT) begin
				pulses_nxt = 5'h00;
				if (pulses_r == `BARS_PULSES_SLOW) begin
					rate_new = 1'b0;
					err_nxt = 1'b0;
				end else if (pulses_r == `BARS_PULSES_FAST) begin
					rate_new = 1'b1;
					err_nxt = 1'b0;
				end else if (pulses_r != 5'h00) begin
					err_nxt = 1'b1;
				end
				fast_nxt = rate_new;
			end
			if (rate_new != fast_r) begin
				settle_nxt = settle_for(rate_new);
			end else if (settle_r != 3'h0) begin
				settle_nxt = settle_r - 3'h1;
			end else if (st_r != ST_SHIFT) begin
				st_nxt = ST_READY;
				dout_nxt = 1'b0;
			end
		end

		if ((st_r != ST_PDOWN) && pd_hit) begin
			st_nxt = ST_PDOWN;
			dout_nxt = 1'b1;
			supply_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= ST_CONV;
			conv_cnt_r <= 32'h0000_0000;
			result_r <= 24'h00_0000;
			shreg_r <= 24'h00_0000;
			pulses_r <= 5'h00;
			settle_r <= SETTLE_SLOW;
			dout_r <= 1'b1;
			fast_r <= `BARS_RATE_RESET;
			supply_r <= 1'b1;
			err_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			conv_cnt_r <= conv_cnt_nxt;
			result_r <= result_nxt;
			shreg_r <= shreg_nxt;
			pulses_r <= pulses_nxt;
			settle_r <= settle_nxt;
			dout_r <= dout_nxt;
			fast_r <= fast_nxt;
			supply_r <= supply_nxt;
			err_r <= err_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	logic pdown_r;

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pdown_r <= 1'b0;
		end else begin
			pdown_r <= (st_nxt == ST_PDOWN);
		end
	end

	assign dout = dout_r;
	assign switched_sensor_supply = supply_r;
	assign rate_fast = fast_r;
	assign powered_down = pdown_r;
	assign comm_error = err_r;

endmodule : bars_top

`default_nettype wire

// file: tb/bars_chk.sv
// Port checker for the bridge converter readout
`timescale 1ns/10ps
`default_nettype none

module bars_chk #(
	parameter int unsigned PD_CYC = 200
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic serial_clock_powerdown,
	input wire logic dout,
	input wire logic switched_sensor_supply,
	input wire logic rate_fast,
	input wire logic powered_down
);
	int unsigned hi_r;
	int unsigned hi_nxt;

	// Raw line high time, held at PD_CYC + 10 once reached even after the line falls, so it cannot wrap
	always_comb begin
		hi_nxt = serial_clock_powerdown ? hi_r + 1 : 0;
		if (hi_r > PD_CYC + 9)
			hi_nxt = hi_r;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			hi_r <= 0;
		else
			hi_r <= hi_nxt;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_sup;
		switched_sensor_supply == !powered_down;
	endproperty
	a_sup: assert property (p_sup) else $error("supply switch wrong");

	property p_pd_dout;
		powered_down |-> dout;
	endproperty
	a_pd_dout: assert property (p_pd_dout) else $error("dout low in sleep");

	property p_pd_entry;
		$rose(powered_down) |-> hi_r > PD_CYC;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("sleep too early");

	property p_pd_late;
		hi_r == PD_CYC + 8 |-> powered_down;
	endproperty
	a_pd_late: assert property (p_pd_late) else $error("sleep missing");

	property p_awake;
		!serial_clock_powerdown [*6] |-> !powered_down;
	endproperty
	a_awake: assert property (p_awake) else $error("asleep, line low");

	property p_exit;
		$fell(powered_down) |->
			!serial_clock_powerdown && !$past(serial_clock_powerdown);
	endproperty
	a_exit: assert property (p_exit) else $error("wake without low line");

	property p_bit;
		$rose(dout) && !powered_down |-> serial_clock_powerdown;
	endproperty
	a_bit: assert property (p_bit) else $error("dout rose, no pulse");

	property p_rate_hold;
		powered_down && $past(powered_down) |-> $stable(rate_fast);
	endproperty
	a_rate_hold: assert property (p_rate_hold) else $error("rate lost");

	c_ready: cover property ($fell(dout));
	c_sleep: cover property ($rose(powered_down));
	c_fast: cover property ($rose(rate_fast));
endmodule : bars_chk

bind bars_top bars_chk #(.PD_CYC(PD_CYC)) i_chk (
	.clk(clk),
	.rstn(rstn),
	.serial_clock_powerdown(serial_clock_powerdown),
	.dout(dout),
	.switched_sensor_supply(switched_sensor_supply),
	.rate_fast(rate_fast),
	.powered_down(powered_down)
);

`default_nettype wire

// file: tb/bars_host.sv
// Host model: drives the shared clock line and samples data
`timescale 1ns/10ps
`default_nettype none

module bars_host (
	input wire logic dout,
	output logic sck
);
	initial sck = 1'b0;

	// Levels kept above 0.2 us; phase drifts against the core clock
	task automatic read(input int n, output logic [23:0] w);
		w = 24'h00_0000;
		for (int i = 0; i < n; i++) begin
			sck = 1'b1;
			#202.3;
			sck = 1'b0;
			#202.3;
			if (i < 24)
				w = {w[22:0], dout};
		end
	endtask : read

	task automatic line(input logic v);
		sck = v;
	endtask : line
endmodule : bars_host

`default_nettype wire

// file: tb/bridge_adc_serial_readout_test.sv
// Self-checking bench for the bridge converter readout
`timescale 1ns/10ps
`default_nettype none

module bridge_adc_serial_readout_test;
	logic clk;
	logic rstn;
	logic sck;
	logic dout;
	logic supply;
	logic rate_fast;
	logic pdn;
	logic err;
	logic [25:0] sample_in;
	logic [23:0] w;
	int fails;
	int check_count;

	bars_top #(.PD_CYC(200), .SLOW_CYC(6000), .FAST_CYC(3000)) i_dut (
		.clk(clk),
		.rstn(rstn),
		.serial_clock_powerdown(sck),
		.sample_in(sample_in),
		.dout(dout),
		.switched_sensor_supply(supply),
		.rate_fast(rate_fast),
		.powered_down(pdn),
		.comm_error(err)
	);

	bars_host i_host (
		.dout(dout),
		.sck(sck)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input string what, input logic [23:0] seen,
		input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	// Bounded wait; a hang ends the run with a mismatch
	task automatic wait_on(ref logic s, input logic lvl, input int lim);
		int k;
		k = 0;
		while (s !== lvl) begin
			@(negedge clk);
			k++;
			if (k > lim) begin
				fails++;
				tally_and_finish();
			end
		end
	endtask : wait_on

	task automatic readout(input int n, input logic [23:0] exp);
		wait_on(dout, 1'b0, 40000);
		i_host.read(n, w);
		check("word", w, exp);
		repeat (8) @(negedge clk);
		check("dout idle", dout, 1'b1);
	endtask : readout

	task automatic t_reset;
		check("dout", dout, 1'b1);
		check("supply", supply, 1'b1);
		check("rate", rate_fast, 1'b0);
		check("pdown", pdn, 1'b0);
		check("error", err, 1'b0);
	endtask : t_reset

	task automatic t_word;
		readout(25, 24'h12_3456);
		sample_in = 26'h100_0000;
	endtask : t_word

	task automatic t_clamp;
		readout(25, 24'h7f_ffff);
		check("rate slow", rate_fast, 1'b0);
		sample_in = 26'h200_0000;
		readout(27, 24'h80_0000);
	endtask : t_clamp

	task automatic t_rate;
		wait_on(rate_fast, 1'b1, 13000);
		// Bad count while still settling: dout must stay high
		i_host.read(26, w);
		check("settling", w, 24'hff_ffff);
		wait_on(err, 1'b1, 1000);
		check("error set", err, 1'b1);
		sample_in = 26'h3ff_fffe;
		readout(27, 24'hff_fffe);
	endtask : t_rate

	// Sleep well past the limit, then wake and read again
	task automatic t_pdown;
		// Let the period with the last count close first
		wait_on(dout, 1'b0, 4000);
		check("error clear", err, 1'b0);
		i_host.line(1'b1);
		repeat (230) @(negedge clk);
		check("pdown", pdn, 1'b1);
		check("supply off", supply, 1'b0);
		check("dout sleep", dout, 1'b1);
		i_host.line(1'b0);
		repeat (8) @(negedge clk);
		check("resume", pdn, 1'b0);
		check("rate kept", rate_fast, 1'b1);
		readout(27, 24'hff_fffe);
	endtask : t_pdown

	initial begin
		rstn = 1'b0;
		sample_in = 26'h012_3456;
		fails = 0;
		check_count = 0;
		repeat (16) @(negedge clk);
		t_reset();
		rstn = 1'b1;
		t_word();
		t_clamp();
		t_rate();
		t_pdown();
		tally_and_finish();
	end
endmodule : bridge_adc_serial_readout_test

`default_nettype wire
